//--- logic/trap_prio_pkg.sv
// Shared constants, types and lookup functions of the interrupt and trap prioritizer
package trap_prio_pkg;

  // Source count and field widths
  localparam int unsigned NUM_SRC = 23;
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned PRIORITY_LEVEL_W = 4;
  localparam int unsigned GROUP_LEVEL_W = 2;
  localparam int unsigned TNUM_W = 7;
  localparam int unsigned VEC_W = 24;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned NUM_CLASS_A = 3;
  localparam int unsigned NUM_CLASS_B = 5;

  // Control byte layout
  localparam int unsigned IR_BIT = 7;
  localparam int unsigned IE_BIT = 6;
  localparam int unsigned PRIORITY_LEVEL_LSB = 2;
  localparam int unsigned GROUP_LEVEL_LSB = 0;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [PRIORITY_LEVEL_W-1:0] PRIORITY_LEVEL_MAX = 4'hF;

  // Fixed trap numbers
  localparam logic [TNUM_W-1:0] TNUM_RESET = 7'h00;
  localparam logic [TNUM_W-1:0] TNUM_NMI = 7'h02;
  localparam logic [TNUM_W-1:0] TNUM_STACK_OVERFLOW = 7'h04;
  localparam logic [TNUM_W-1:0] TNUM_STACK_UNDERFLOW = 7'h06;
  localparam logic [TNUM_W-1:0] TNUM_CLASS_B = 7'h0A;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_SRC_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_TRAP_FLAG = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h104;

  // Trap flag register bit positions
  localparam int unsigned TF_NMI = 15;
  localparam int unsigned TF_STACK_OVERFLOW = 14;
  localparam int unsigned TF_STACK_UNDERFLOW = 13;
  localparam int unsigned TF_CLASS_B_LSB = 0;

  // Status register fields
  localparam int unsigned STAT_RUN_LSB = 0;
  localparam int unsigned STAT_OFFER = 2;
  localparam int unsigned STAT_SW = 3;
  localparam int unsigned STAT_RST = 4;
  localparam int unsigned STAT_NUM_LSB = 8;

  typedef enum logic [1:0] {CLS_NONE, CLS_B, CLS_A, CLS_RESET} trap_class_t;
  typedef enum logic [1:0] {KIND_NONE, KIND_TRAP, KIND_SW, KIND_INT} offer_kind_t;

  function automatic logic [VEC_W-1:0] trap_vector(input logic [TNUM_W-1:0] num);
    return VEC_W'({num, 2'b00});
  endfunction

  function automatic logic [TNUM_W-1:0] src_trap_num(input int unsigned idx);
    case (idx)
      0: return 7'h21;
      1: return 7'h3D;
      2: return 7'h3E;
      3: return 7'h22;
      4: return 7'h23;
      5: return 7'h24;
      6: return 7'h25;
      7: return 7'h26;
      8: return 7'h27;
      9: return 7'h28;
      10: return 7'h29;
      11: return 7'h2A;
      12: return 7'h47;
      13: return 7'h2B;
      14: return 7'h2C;
      15: return 7'h2D;
      16: return 7'h2E;
      17: return 7'h2F;
      18: return 7'h3F;
      19: return 7'h40;
      20: return 7'h41;
      21: return 7'h42;
      22: return 7'h43;
      default: return TNUM_RESET;
    endcase
  endfunction

endpackage

//--- logic/pin_sync.sv
// Three-stage synchroniser that accepts a change once the last two stages agree
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Pin and filtered level
  input wire logic pin_in,
  output logic level
);

  logic [2:0] stage_reg;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_reg <= {3{RESET_VAL}};
    end else if (clk_en) begin
      stage_reg <= {stage_reg[1:0], pin_in};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      level <= RESET_VAL;
    end else if (clk_en && (stage_reg[1] == stage_reg[2])) begin
      level <= stage_reg[2];
    end
  end

endmodule // pin_sync

//--- logic/prio_pick.sv
// Picks the enabled pending source with the highest level, then group
`timescale 1ns/1ps
module prio_pick #(
  parameter int unsigned NUM_SRC = trap_prio_pkg::NUM_SRC,
  parameter int unsigned IDX_W = 5
) (
  // Flattened control bytes
  input wire logic [NUM_SRC*trap_prio_pkg::CTRL_W-1:0] ctrl_flat,
  // Winner
  output logic win_valid,
  output logic [IDX_W-1:0] win_idx,
  output logic [trap_prio_pkg::PRIORITY_LEVEL_W-1:0] win_priority_level
);

  localparam int unsigned KEY_W = trap_prio_pkg::PRIORITY_LEVEL_W + trap_prio_pkg::GROUP_LEVEL_W;

  always_comb begin
    logic [trap_prio_pkg::CTRL_W-1:0] c;
    logic [KEY_W-1:0] key;
    logic [KEY_W-1:0] best_key;
    c = '0;
    key = '0;
    best_key = '0;
    win_valid = 1'b0;
    win_idx = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      c = ctrl_flat[i*trap_prio_pkg::CTRL_W +: trap_prio_pkg::CTRL_W];
      key = c[trap_prio_pkg::GROUP_LEVEL_LSB +: KEY_W];
      // Level first, group breaks ties, lowest index on full tie
      if (c[trap_prio_pkg::IR_BIT] && c[trap_prio_pkg::IE_BIT] && (!win_valid || key > best_key)) begin
        win_valid = 1'b1;
        win_idx = IDX_W'(i);
        best_key = key;
      end
    end
    win_priority_level = best_key[KEY_W-1 -: trap_prio_pkg::PRIORITY_LEVEL_W];
  end

endmodule // prio_pick

//--- logic/interrupt_trap_prioritizer.sv
// Interrupt and hardware trap prioritizer with APB control registers
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps

// Summary of operation
// - Priority level Fh ranks most urgent, 0h least urgent.
// - Among equal levels, group level 3 wins and 0 loses.
// - A request joins arbitration only while its enable bit is one.
// - Request flag reads one while a request is outstanding.
// - Low byte holds flag bit 7, enable 6, level 5:2, group 1:0.
// - Upper control byte reads zero and ignores writes.
// - Every control bit is readable and writable by software.
// - Each source has a fixed trap number and vector location.
// - Hardware traps cannot be masked and branch to their own vector.
// - Each hardware trap sets its own bit in the trap flag register.
// - A trap pre-empts everything except a running trap of equal or higher class.
// - Interrupts cannot interrupt a running hardware trap service.
// - All resets share top priority, trap number 00h, vector 0.
// - Class A traps rank second with vectors 08h, 10h, 18h.
// - Class B traps share vector 28h, number 0Ah, rank third.
// - Reset and hardware trap service force CPU level to 15.
module interrupt_trap_prioritizer #(
  parameter int unsigned NUM_SRC = trap_prio_pkg::NUM_SRC
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // APB slave
  input wire logic [trap_prio_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral request strobes
  input wire logic [NUM_SRC-1:0] src_req,
  // Trap and reset events
  input wire logic nmi_b,
  input wire logic stack_overflow,
  input wire logic stack_underflow,
  input wire logic [trap_prio_pkg::NUM_CLASS_B-1:0] class_b_fault,
  input wire logic sw_reset_req,
  input wire logic wdt_overflow,
  // CPU side
  input wire logic [trap_prio_pkg::PRIORITY_LEVEL_W-1:0] cpu_priority_level,
  input wire logic cpu_ack,
  input wire logic trap_done,
  input wire logic sw_trap_req,
  input wire logic [trap_prio_pkg::TNUM_W-1:0] sw_trap_num,
  output logic offer_valid,
  output logic [trap_prio_pkg::TNUM_W-1:0] offer_trap_num,
  output logic [trap_prio_pkg::VEC_W-1:0] offer_vector,
  output logic [trap_prio_pkg::PRIORITY_LEVEL_W-1:0] offer_priority_level,
  output logic offer_hw_trap,
  output logic trap_service
);

  localparam int unsigned IDX_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;
  localparam int unsigned CW = trap_prio_pkg::CTRL_W;
  localparam int unsigned SRC_SPAN = NUM_SRC * 4;

  // Register file and pending state
  logic [CW-1:0] ctrl_reg [NUM_SRC];
  logic [15:0] trap_flag_reg;
  logic rst_pend_reg;
  logic [trap_prio_pkg::NUM_CLASS_A-1:0] a_pend_reg;
  logic b_pend_reg;
  logic sw_pend_reg;
  logic [trap_prio_pkg::TNUM_W-1:0] sw_num_reg;
  trap_prio_pkg::trap_class_t run_cls_reg;

  // Registered offer bookkeeping
  trap_prio_pkg::offer_kind_t kind_reg;
  trap_prio_pkg::trap_class_t cls_reg;
  logic [1:0] abit_reg;
  logic [IDX_W-1:0] idx_reg;

  // NMI edge detection
  logic nmi_level;
  logic nmi_prev_reg;
  logic nmi_evt;

  // Arbiter
  logic [NUM_SRC*CW-1:0] ctrl_flat;
  logic win_valid;
  logic [IDX_W-1:0] win_idx;
  logic [trap_prio_pkg::PRIORITY_LEVEL_W-1:0] win_priority_level;

  // Candidate offer
  trap_prio_pkg::trap_class_t cand_cls;
  trap_prio_pkg::offer_kind_t cand_kind;
  logic [1:0] cand_abit;
  logic cand_valid;
  logic [trap_prio_pkg::TNUM_W-1:0] cand_num;
  logic [trap_prio_pkg::PRIORITY_LEVEL_W-1:0] cand_priority_level;
  logic cand_hw;

  // Bus decode
  logic apb_access;
  logic apb_commit;
  logic wr_en;
  logic rd_hit;
  logic [31:0] rd_val;
  logic [31:0] status_val;

  // Acknowledge decode
  logic ack;
  logic ack_trap;
  logic ack_sw;
  logic ack_int;

  function automatic logic src_hit(input logic [trap_prio_pkg::ADDR_W-1:0] a);
    return (a >= trap_prio_pkg::OFF_SRC_BASE) && (a < trap_prio_pkg::OFF_SRC_BASE + SRC_SPAN)
           && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [IDX_W-1:0] src_index(input logic [trap_prio_pkg::ADDR_W-1:0] a);
    logic [trap_prio_pkg::ADDR_W-1:0] rel;
    rel = a - trap_prio_pkg::OFF_SRC_BASE;
    return IDX_W'(rel >> 2);
  endfunction

  pin_sync #(
    .RESET_VAL(1'b1)
  ) nmi_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .pin_in(nmi_b),
    .level(nmi_level)
  );

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_prev_reg <= 1'b1;
    end else if (clk_en) begin
      nmi_prev_reg <= nmi_level;
    end
  end

  assign nmi_evt = nmi_prev_reg & ~nmi_level;

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      ctrl_flat[i*CW +: CW] = ctrl_reg[i];
    end
  end

  prio_pick #(
    .NUM_SRC(NUM_SRC),
    .IDX_W(IDX_W)
  ) arbiter (
    .ctrl_flat(ctrl_flat),
    .win_valid(win_valid),
    .win_idx(win_idx),
    .win_priority_level(win_priority_level)
  );

  // APB: one wait state, data and answer registered
  assign apb_access = psel & penable & ~pready;
  assign apb_commit = psel & penable & pready;
  assign wr_en = apb_commit & pwrite & ~pslverr;

  always_comb begin
    status_val = '0;
    status_val[trap_prio_pkg::STAT_RUN_LSB +: 2] = run_cls_reg;
    status_val[trap_prio_pkg::STAT_OFFER] = offer_valid;
    status_val[trap_prio_pkg::STAT_SW] = sw_pend_reg;
    status_val[trap_prio_pkg::STAT_RST] = rst_pend_reg;
    status_val[trap_prio_pkg::STAT_NUM_LSB +: trap_prio_pkg::TNUM_W] = offer_trap_num;
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = '0;
    if (src_hit(paddr)) begin
      rd_val = 32'(ctrl_reg[src_index(paddr)]);
    end else if (paddr == trap_prio_pkg::OFF_TRAP_FLAG) begin
      rd_val = 32'(trap_flag_reg);
    end else if (paddr == trap_prio_pkg::OFF_STATUS) begin
      rd_val = status_val;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (clk_en) begin
      pready <= apb_access;
      pslverr <= apb_access & ~rd_hit;
      if (apb_access && !pwrite) begin
        prdata <= rd_hit ? rd_val : '0;
      end
    end
  end

  // Acknowledge consumes what the CPU saw on the offer outputs
  assign ack = offer_valid & cpu_ack;
  assign ack_trap = ack && (kind_reg == trap_prio_pkg::KIND_TRAP);
  assign ack_sw = ack && (kind_reg == trap_prio_pkg::KIND_SW);
  assign ack_int = ack && (kind_reg == trap_prio_pkg::KIND_INT);

  // Control registers; hardware set beats software or acknowledge clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        ctrl_reg[i] <= trap_prio_pkg::CTRL_RESET;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (wr_en && pstrb[0] && src_hit(paddr) && (src_index(paddr) == IDX_W'(i))) begin
          ctrl_reg[i] <= pwdata[CW-1:0];
        end
        if (ack_int && (idx_reg == IDX_W'(i))) begin
          ctrl_reg[i][trap_prio_pkg::IR_BIT] <= 1'b0;
        end
        if (src_req[i]) begin
          ctrl_reg[i][trap_prio_pkg::IR_BIT] <= 1'b1;
        end
      end
    end
  end

  // Trap flags: write one to clear, new trap wins
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trap_flag_reg <= '0;
    end else if (clk_en) begin
      trap_flag_reg <= (wr_en && (paddr == trap_prio_pkg::OFF_TRAP_FLAG))
        ? (trap_flag_reg & ~{pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00})
        : trap_flag_reg;
      if (nmi_evt) trap_flag_reg[trap_prio_pkg::TF_NMI] <= 1'b1;
      if (stack_overflow) trap_flag_reg[trap_prio_pkg::TF_STACK_OVERFLOW] <= 1'b1;
      if (stack_underflow) trap_flag_reg[trap_prio_pkg::TF_STACK_UNDERFLOW] <= 1'b1;
      for (int j = 0; j < trap_prio_pkg::NUM_CLASS_B; j++) begin
        if (class_b_fault[j]) trap_flag_reg[trap_prio_pkg::TF_CLASS_B_LSB + j] <= 1'b1;
      end
    end
  end

  // Pending resets and traps; hardware reset leaves a reset pending
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pend_reg <= 1'b1;
      a_pend_reg <= '0;
      b_pend_reg <= 1'b0;
    end else if (clk_en) begin
      if (ack_trap && (cls_reg == trap_prio_pkg::CLS_RESET)) rst_pend_reg <= 1'b0;
      if (ack_trap && (cls_reg == trap_prio_pkg::CLS_A)) a_pend_reg[abit_reg] <= 1'b0;
      if (ack_trap && (cls_reg == trap_prio_pkg::CLS_B)) b_pend_reg <= 1'b0;
      if (sw_reset_req || wdt_overflow) rst_pend_reg <= 1'b1;
      if (nmi_evt) a_pend_reg[0] <= 1'b1;
      if (stack_overflow) a_pend_reg[1] <= 1'b1;
      if (stack_underflow) a_pend_reg[2] <= 1'b1;
      if (|class_b_fault) b_pend_reg <= 1'b1;
    end
  end

  // Software trap request
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_pend_reg <= 1'b0;
      sw_num_reg <= '0;
    end else if (clk_en) begin
      if (ack_sw) sw_pend_reg <= 1'b0;
      if (sw_trap_req) begin
        sw_pend_reg <= 1'b1;
        sw_num_reg <= sw_trap_num;
      end
    end
  end

  // Running trap class
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_cls_reg <= trap_prio_pkg::CLS_NONE;
      trap_service <= 1'b0;
    end else if (clk_en) begin
      if (ack_trap) begin
        run_cls_reg <= cls_reg;
        trap_service <= 1'b1;
      end else if (trap_done) begin
        run_cls_reg <= trap_prio_pkg::CLS_NONE;
        trap_service <= 1'b0;
      end
    end
  end

  // Candidate selection
  always_comb begin
    cand_cls = trap_prio_pkg::CLS_NONE;
    cand_abit = 2'd0;
    if (rst_pend_reg) begin
      cand_cls = trap_prio_pkg::CLS_RESET;
    end else if (|a_pend_reg) begin
      cand_cls = trap_prio_pkg::CLS_A;
      cand_abit = a_pend_reg[0] ? 2'd0 : (a_pend_reg[1] ? 2'd1 : 2'd2);
    end else if (b_pend_reg) begin
      cand_cls = trap_prio_pkg::CLS_B;
    end
    cand_valid = 1'b0;
    cand_kind = trap_prio_pkg::KIND_NONE;
    cand_num = trap_prio_pkg::TNUM_RESET;
    cand_priority_level = cpu_priority_level;
    cand_hw = 1'b0;
    if (cand_cls > run_cls_reg) begin
      cand_valid = 1'b1;
      cand_kind = trap_prio_pkg::KIND_TRAP;
      cand_hw = 1'b1;
      cand_priority_level = trap_prio_pkg::PRIORITY_LEVEL_MAX;
      case (cand_cls)
        trap_prio_pkg::CLS_RESET: cand_num = trap_prio_pkg::TNUM_RESET;
        trap_prio_pkg::CLS_A: begin
          case (cand_abit)
            2'd0: cand_num = trap_prio_pkg::TNUM_NMI;
            2'd1: cand_num = trap_prio_pkg::TNUM_STACK_OVERFLOW;
            default: cand_num = trap_prio_pkg::TNUM_STACK_UNDERFLOW;
          endcase
        end
        default: cand_num = trap_prio_pkg::TNUM_CLASS_B;
      endcase
    end else if (run_cls_reg == trap_prio_pkg::CLS_NONE) begin
      if (sw_pend_reg) begin
        cand_valid = 1'b1;
        cand_kind = trap_prio_pkg::KIND_SW;
        cand_num = sw_num_reg;
      end else if (win_valid && (win_priority_level > cpu_priority_level)) begin
        cand_valid = 1'b1;
        cand_kind = trap_prio_pkg::KIND_INT;
        cand_num = trap_prio_pkg::src_trap_num(32'(win_idx));
        cand_priority_level = win_priority_level;
      end
    end
  end

  // Offer outputs, refreshed every cycle, dropped for one cycle on acknowledge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      offer_valid <= 1'b0;
      offer_trap_num <= '0;
      offer_vector <= '0;
      offer_priority_level <= '0;
      offer_hw_trap <= 1'b0;
      kind_reg <= trap_prio_pkg::KIND_NONE;
      cls_reg <= trap_prio_pkg::CLS_NONE;
      abit_reg <= 2'd0;
      idx_reg <= '0;
    end else if (clk_en) begin
      offer_valid <= cand_valid & ~ack;
      offer_trap_num <= cand_num;
      offer_vector <= trap_prio_pkg::trap_vector(cand_num);
      offer_priority_level <= cand_priority_level;
      offer_hw_trap <= cand_hw;
      kind_reg <= cand_kind;
      cls_reg <= cand_cls;
      abit_reg <= cand_abit;
      idx_reg <= win_idx;
    end
  end

endmodule // interrupt_trap_prioritizer

//--- sim/itp_asserts.sv
// Checker of offer, trap service and APB timing
`timescale 1ns/1ps
module itp_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // APB
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // CPU side
  input wire logic [3:0] cpu_priority_level,
  input wire logic cpu_ack,
  input wire logic offer_valid,
  input wire logic [6:0] offer_trap_num,
  input wire logic [23:0] offer_vector,
  input wire logic [3:0] offer_priority_level,
  input wire logic offer_hw_trap,
  input wire logic trap_service
);
  logic [7:0] priority_level_q;
  logic hw_acked;
  logic steady;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      priority_level_q <= 8'h00;
      hw_acked <= 1'b0;
    end else begin
      priority_level_q <= {priority_level_q[3:0], cpu_priority_level};
      hw_acked <= cpu_ack && offer_valid && offer_hw_trap;
    end
  end
  // CPU level unchanged over the offer pipeline
  assign steady = priority_level_q[7:4] == cpu_priority_level && priority_level_q[3:0] == cpu_priority_level;
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_access;
    psel && penable;
  endsequence
  AST_APB_WAIT: assert property (apb_setup ##1 apb_access |=> pready)
    else $error("pready late");
  AST_UPPER_ZERO: assert property (pready && psel && !pwrite && paddr <= 12'h058 |-> prdata[31:8] == 24'h0)
    else $error("upper byte not zero");
  AST_TRAP_LEVEL: assert property (offer_valid && offer_hw_trap |-> offer_priority_level == 4'hF)
    else $error("trap level not 15");
  AST_VECTOR: assert property (offer_valid |-> offer_vector == {15'h0, offer_trap_num, 2'b00})
    else $error("vector mismatch");
  AST_TRAP_NUM: assert property (offer_valid && offer_hw_trap |-> offer_trap_num inside {7'h00, 7'h02, 7'h04, 7'h06, 7'h0A})
    else $error("bad trap number");
  AST_NO_INT_IN_SERVICE: assert property (trap_service && offer_valid |-> offer_hw_trap)
    else $error("interrupt during trap");
  AST_ABOVE_CPU: assert property (offer_valid && !offer_hw_trap && steady |-> offer_priority_level >= cpu_priority_level)
    else $error("offer below cpu level");
  AST_ACK_CLEARS: assert property (cpu_ack && offer_valid |=> !offer_valid)
    else $error("offer stands after ack");
  AST_SERVICE_START: assert property ($rose(trap_service) |-> hw_acked)
    else $error("service without trap ack");
endmodule // itp_asserts

bind interrupt_trap_prioritizer itp_asserts itp_asserts_i (
  .ref_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .prdata, .pready, .cpu_priority_level, .cpu_ack,
  .offer_valid, .offer_trap_num, .offer_vector, .offer_priority_level, .offer_hw_trap, .trap_service
);

//--- sim/cpu_model.sv
// CPU that takes each offer after a set wait and logs it
`timescale 1ns/1ps
module cpu_model (
  // Clock, reset, pacing
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [3:0] ack_delay,
  // Offer
  input wire logic offer_valid,
  input wire logic [6:0] offer_trap_num,
  input wire logic [23:0] offer_vector,
  input wire logic [3:0] offer_priority_level,
  input wire logic offer_hw_trap,
  output logic cpu_ack,
  // Log of last taken offer
  output logic [7:0] got_cnt,
  output logic [35:0] got
);
  logic [3:0] wait_cnt;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_ack <= 1'b0;
      wait_cnt <= 4'h0;
      got_cnt <= 8'h00;
      got <= 36'h0;
    end else begin
      cpu_ack <= 1'b0;
      if (cpu_ack && offer_valid) begin
        got_cnt <= got_cnt + 8'h01;
        got <= {offer_hw_trap, offer_priority_level, offer_vector, offer_trap_num};
        wait_cnt <= 4'h0;
      end else if (offer_valid && !cpu_ack) begin
        wait_cnt <= wait_cnt + 4'h1;
        cpu_ack <= wait_cnt >= ack_delay;
      end else begin
        wait_cnt <= 4'h0;
      end
    end
  end
endmodule // cpu_model

//--- sim/interrupt_trap_prioritizer_tb.sv
// Self-checking bench of the prioritizer
`timescale 1ns/1ps
module interrupt_trap_prioritizer_tb;
  logic ref_clk, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nmi_b = 1'b1;
  logic stack_overflow = 1'b0, stack_underflow = 1'b0, sw_reset_req = 1'b0, wdt_overflow = 1'b0;
  logic trap_done = 1'b0, sw_trap_req = 1'b0, cpu_ack, pready, pslverr, offer_valid, offer_hw_trap, trap_service;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0] pstrb = 4'hF, cpu_priority_level = 4'h0, ack_delay = 4'h3, offer_priority_level;
  logic [22:0] src_req = 23'h0;
  logic [4:0] class_b_fault = 5'h00;
  logic [6:0] sw_trap_num = 7'h00, offer_trap_num;
  logic [23:0] offer_vector;
  logic [7:0] got_cnt, seen = 8'h00;
  logic [35:0] got;
  logic e;
  int fails = 0;
  int num_checks = 0;
  logic [6:0] tbl [23] = '{7'h21, 7'h3D, 7'h3E, 7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27, 7'h28, 7'h29, 7'h2A,
    7'h47, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F, 7'h3F, 7'h40, 7'h41, 7'h42, 7'h43};

  interrupt_trap_prioritizer interrupt_trap_prioritizer_i (
    .ref_clk, .rst_b, .clk_en(1'b1), .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .src_req, .nmi_b, .stack_overflow, .stack_underflow, .class_b_fault, .sw_reset_req,
    .wdt_overflow, .cpu_priority_level, .cpu_ack, .trap_done, .sw_trap_req, .sw_trap_num, .offer_valid,
    .offer_trap_num, .offer_vector, .offer_priority_level, .offer_hw_trap, .trap_service
  );
  cpu_model cpu_model_i (
    .ref_clk, .rst_b, .ack_delay, .offer_valid, .offer_trap_num, .offer_vector, .offer_priority_level,
    .offer_hw_trap, .cpu_ack, .got_cnt, .got
  );

  task automatic chk(input string nm, input logic [35:0] s, input logic [35:0] x);
    num_checks++;
    if (s !== x) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, x, s);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 36'(pready), 36'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("read", {e, 3'h0, q}, {4'h0, x});
  endtask

  // Waits for the next taken offer and compares all its fields
  task automatic take(input logic [6:0] n, input logic [3:0] l, input logic h);
    int k;
    k = 0;
    while (got_cnt === seen && k < 60) begin
      @(posedge ref_clk);
      k++;
    end
    chk("ack count", 36'(got_cnt), 36'(seen + 8'h01));
    seen = got_cnt;
    chk("offer", got, {h, l, 15'h0, n, 2'b00, n});
  endtask

  task automatic quiet;
    repeat (10) @(posedge ref_clk);
    chk("no offer", 36'(got_cnt), 36'(seen));
  endtask

  task automatic done;
    @(posedge ref_clk);
    trap_done <= 1'b1;
    @(posedge ref_clk);
    trap_done <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic pulse(input logic [22:0] s);
    @(posedge ref_clk);
    src_req <= s;
    @(posedge ref_clk);
    src_req <= 23'h0;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    #50000;
    fails++;
    finish_test;
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    take(7'h00, 4'hF, 1'b1);
    chk("service", 36'(trap_service), 36'h1);
    done;
    chk("service end", 36'(trap_service), 36'h0);
    for (int j = 0; j < 2; j++) begin
      @(posedge ref_clk);
      wdt_overflow <= j == 0;
      sw_reset_req <= j == 1;
      @(posedge ref_clk);
      wdt_overflow <= 1'b0;
      sw_reset_req <= 1'b0;
      take(7'h00, 4'hF, 1'b1);
      done;
    end
    cpu_priority_level <= 4'hF;
    rd(12'h008, 32'h0);
    apb(1'b1, 12'h008, 32'hFFFFFFFF);
    rd(12'h008, 32'hFF);
    apb(1'b1, 12'h008, 32'h0);
    rd(12'h008, 32'h0);
    pstrb <= 4'hE;
    apb(1'b1, 12'h008, 32'hFF);
    pstrb <= 4'hF;
    rd(12'h008, 32'h0);
    apb(1'b0, 12'h0F0, 32'h0);
    chk("unmapped", {e, 3'h0, q}, 36'h800000000);
    cpu_priority_level <= 4'h0;
    ack_delay <= 4'h0;
    for (int i = 0; i < 23; i++) begin
      apb(1'b1, 12'(4 * i), 32'h44);
      pulse(23'h1 << i);
      take(tbl[i], 4'h1, 1'b0);
    end
    ack_delay <= 4'h3;
    apb(1'b1, 12'h00C, 32'h5C);
    apb(1'b1, 12'h010, 32'h5F);
    apb(1'b1, 12'h014, 32'h48);
    apb(1'b1, 12'h018, 32'h78);
    pulse(23'h000078);
    take(7'h25, 4'hE, 1'b0);
    take(7'h23, 4'h7, 1'b0);
    take(7'h22, 4'h7, 1'b0);
    take(7'h24, 4'h2, 1'b0);
    apb(1'b1, 12'h054, 32'h14);
    pulse(23'h200000);
    rd(12'h054, 32'h94);
    quiet;
    cpu_priority_level <= 4'h5;
    apb(1'b1, 12'h054, 32'hD4);
    quiet;
    cpu_priority_level <= 4'h4;
    take(7'h42, 4'h5, 1'b0);
    rd(12'h054, 32'h54);
    cpu_priority_level <= 4'h3;
    sw_trap_num <= 7'h7F;
    sw_trap_req <= 1'b1;
    @(posedge ref_clk);
    sw_trap_req <= 1'b0;
    take(7'h7F, 4'h3, 1'b0);
    cpu_priority_level <= 4'h0;
    apb(1'b1, 12'h000, 32'h7C);
    src_req <= 23'h1;
    stack_underflow <= 1'b1;
    class_b_fault <= 5'h1F;
    @(posedge ref_clk);
    src_req <= 23'h0;
    stack_underflow <= 1'b0;
    class_b_fault <= 5'h00;
    take(7'h06, 4'hF, 1'b1);
    quiet;
    done;
    take(7'h0A, 4'hF, 1'b1);
    stack_overflow <= 1'b1;
    @(posedge ref_clk);
    stack_overflow <= 1'b0;
    take(7'h04, 4'hF, 1'b1);
    done;
    take(7'h21, 4'hF, 1'b0);
    rd(12'h100, 32'h601F);
    apb(1'b1, 12'h100, 32'hFFFF);
    rd(12'h100, 32'h0);
    nmi_b <= 1'b0;
    take(7'h02, 4'hF, 1'b1);
    rd(12'h100, 32'h8000);
    rd(12'h104, 32'h2);
    done;
    nmi_b <= 1'b1;
    finish_test;
  end
endmodule // interrupt_trap_prioritizer_tb
